// [common/pwm_irq_pkg.sv]
package pwm_irq_pkg;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int CHANNELS = 6;
	localparam int PAIRS = 3;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] SOFT_BRAKE_OFS = 8'hdc;
	localparam logic [ADDR_W-1:0] EVENT_EN_OFS = 8'he0;
	localparam logic [ADDR_W-1:0] BRAKE_EN_OFS = 8'he4;
	localparam logic [ADDR_W-1:0] EVENT_FLAG_OFS = 8'he8;
	localparam logic [ADDR_W-1:0] BRAKE_FLAG_OFS = 8'hec;

	// ------------------------------------------------------------
	// field layout and reset values
	// ------------------------------------------------------------
	localparam int CMPD_LSB = 24;
	localparam int CMPU_LSB = 16;
	localparam int PERIOD_LSB = 8;
	localparam int ZERO_LSB = 0;
	localparam int EDGE_LSB = 0;
	localparam int LEVEL_LSB = 8;
	localparam logic [DATA_W-1:0] EVENT_MASK = 32'h3f3f_1515;
	localparam logic [DATA_W-1:0] BRAKE_MASK = 32'h0000_0707;
	localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_RESP = 2'b10
	} rd_state_t;

	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [STRB_W-1:0] strb;
	} reg_write_t;

	typedef struct packed {
		logic [CHANNELS-1:0] cmp_down;
		logic [CHANNELS-1:0] cmp_up;
		logic [PAIRS-1:0] period_hit;
		logic [PAIRS-1:0] center_hit;
		logic [PAIRS-1:0] zero_hit;
		logic [PAIRS-1:0] edge_brake;
		logic [PAIRS-1:0] level_brake;
	} pwm_events_t;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [ADDR_W-1:0] word_of(input logic [ADDR_W-1:0] a);
		word_of = {a[ADDR_W-1:2], 2'h0};
	endfunction

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] w;
		w = word_of(a);
		addr_mapped = (w == SOFT_BRAKE_OFS) || (w == EVENT_EN_OFS) || (w == BRAKE_EN_OFS) ||
			(w == EVENT_FLAG_OFS) || (w == BRAKE_FLAG_OFS);
	endfunction

	function automatic logic [DATA_W-1:0] apply_strb(input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] data, input logic [STRB_W-1:0] strb);
		apply_strb = old;
		for (int i = 0; i < STRB_W; i++) begin
			if (strb[i]) begin
				apply_strb[i*8 +: 8] = data[i*8 +: 8];
			end
		end
	endfunction

endpackage

// [hw/axil_reg_slave.sv]
`timescale 1ns/100ps
module axil_reg_slave (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [pwm_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pwm_irq_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [pwm_irq_pkg::STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [pwm_irq_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [pwm_irq_pkg::DATA_W-1:0] rd_data,
	input wire logic rd_hit,
	output pwm_irq_pkg::reg_write_t wr_req
);

	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
	logic arready_q, arready_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [pwm_irq_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [pwm_irq_pkg::DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [pwm_irq_pkg::STRB_W-1:0] wstrb_q, wstrb_d;
	pwm_irq_pkg::reg_write_t wr_q, wr_d;
	pwm_irq_pkg::rd_state_t rd_q, rd_d;

	// ------------------------------------------------------------
	// write channels
	// ------------------------------------------------------------
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		wr_d = '0;
		if (s_axi_awvalid && awready_q) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (aw_have_q && w_have_q && !bvalid_q) begin
			wr_d.valid = pwm_irq_pkg::addr_mapped(awaddr_q);
			wr_d.addr = pwm_irq_pkg::word_of(awaddr_q);
			wr_d.data = wdata_q;
			wr_d.strb = wstrb_q;
			bvalid_d = 1'b1;
			bresp_d = pwm_irq_pkg::addr_mapped(awaddr_q) ? pwm_irq_pkg::RESP_OKAY : pwm_irq_pkg::RESP_SLVERR;
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
		end
		awready_d = !aw_have_d;
		wready_d = !w_have_d;
	end

	// ------------------------------------------------------------
	// read channels
	// ------------------------------------------------------------
	always_comb begin
		rd_d = rd_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		case (rd_q)
			pwm_irq_pkg::RD_IDLE: begin
				if (s_axi_arvalid && arready_q) begin
					rdata_d = rd_data;
					rresp_d = rd_hit ? pwm_irq_pkg::RESP_OKAY : pwm_irq_pkg::RESP_SLVERR;
					rd_d = pwm_irq_pkg::RD_RESP;
				end
			end
			pwm_irq_pkg::RD_RESP: begin
				if (s_axi_rready) begin
					rd_d = pwm_irq_pkg::RD_IDLE;
				end
			end
			default: begin
				rd_d = pwm_irq_pkg::RD_IDLE;
			end
		endcase
		arready_d = (rd_d == pwm_irq_pkg::RD_IDLE);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= pwm_irq_pkg::RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			wr_q <= '0;
			rd_q <= pwm_irq_pkg::RD_IDLE;
			arready_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= pwm_irq_pkg::RESP_OKAY;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			arready_q <= arready_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = (rd_q == pwm_irq_pkg::RD_RESP);
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign wr_req = wr_q;

endmodule

// [hw/pwm_irq_enable.sv]
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
module pwm_irq_enable (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [pwm_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pwm_irq_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [pwm_irq_pkg::STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pwm_irq_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [pwm_irq_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire pwm_irq_pkg::pwm_events_t events,
	input wire logic [pwm_irq_pkg::PAIRS-1:0] comp_mode,
	input wire logic [pwm_irq_pkg::PAIRS-1:0] up_down_mode,
	input wire logic register_write_lock,
	output logic [pwm_irq_pkg::PAIRS-1:0] soft_level_brake_trigger,
	output logic [pwm_irq_pkg::PAIRS-1:0] soft_edge_brake_trigger,
	output logic [pwm_irq_pkg::CHANNELS-1:0] chan_irq,
	output logic pwm_irq
);

	pwm_irq_pkg::reg_write_t wr;
	logic [pwm_irq_pkg::DATA_W-1:0] ev_en_q, ev_en_d, brk_en_q, brk_en_d;
	logic [pwm_irq_pkg::DATA_W-1:0] ev_flag_q, ev_flag_d, brk_flag_q, brk_flag_d;
	logic [pwm_irq_pkg::DATA_W-1:0] ev_set, brk_set, ev_clr, brk_clr, wr_word;
	logic [pwm_irq_pkg::DATA_W-1:0] rd_word, ev_hot, brk_hot;
	logic [pwm_irq_pkg::PAIRS-1:0] lvl_trig_q, lvl_trig_d, edge_trig_q, edge_trig_d;
	logic [pwm_irq_pkg::CHANNELS-1:0] chan_req, chan_irq_q;
	logic irq_q, irq_d, unlocked;

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	axil_reg_slave bus (
		.ref_clk(ref_clk),
		.srst(srst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rd_data(rd_word),
		.rd_hit(pwm_irq_pkg::addr_mapped(s_axi_araddr)),
		.wr_req(wr)
	);

	// ------------------------------------------------------------
	// read decode
	// ------------------------------------------------------------
	always_comb begin
		case (pwm_irq_pkg::word_of(s_axi_araddr))
			pwm_irq_pkg::EVENT_EN_OFS: rd_word = ev_en_q & pwm_irq_pkg::EVENT_MASK;
			pwm_irq_pkg::BRAKE_EN_OFS: rd_word = brk_en_q & pwm_irq_pkg::BRAKE_MASK;
			pwm_irq_pkg::EVENT_FLAG_OFS: rd_word = ev_flag_q;
			pwm_irq_pkg::BRAKE_FLAG_OFS: rd_word = brk_flag_q;
			default: rd_word = pwm_irq_pkg::REG_RESET;
		endcase
	end

	// ------------------------------------------------------------
	// event sources placed at flag positions
	// ------------------------------------------------------------
	always_comb begin
		ev_set = pwm_irq_pkg::REG_RESET;
		brk_set = pwm_irq_pkg::REG_RESET;
		ev_set[pwm_irq_pkg::CMPD_LSB +: pwm_irq_pkg::CHANNELS] = events.cmp_down;
		ev_set[pwm_irq_pkg::CMPU_LSB +: pwm_irq_pkg::CHANNELS] = events.cmp_up;
		for (int k = 0; k < pwm_irq_pkg::PAIRS; k++) begin
			ev_set[pwm_irq_pkg::PERIOD_LSB + 2*k] = up_down_mode[k] ? events.center_hit[k] : events.period_hit[k];
			ev_set[pwm_irq_pkg::ZERO_LSB + 2*k] = events.zero_hit[k];
		end
		brk_set[pwm_irq_pkg::LEVEL_LSB +: pwm_irq_pkg::PAIRS] = events.level_brake | lvl_trig_d;
		brk_set[pwm_irq_pkg::EDGE_LSB +: pwm_irq_pkg::PAIRS] = events.edge_brake | edge_trig_d;
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	assign unlocked = !register_write_lock;
	assign wr_word = pwm_irq_pkg::apply_strb(pwm_irq_pkg::REG_RESET, wr.data, wr.strb);

	always_comb begin
		ev_en_d = ev_en_q;
		brk_en_d = brk_en_q;
		ev_clr = pwm_irq_pkg::REG_RESET;
		brk_clr = pwm_irq_pkg::REG_RESET;
		lvl_trig_d = '0;
		edge_trig_d = '0;
		if (wr.valid) begin
			case (wr.addr)
				pwm_irq_pkg::EVENT_EN_OFS: begin
					ev_en_d = pwm_irq_pkg::apply_strb(ev_en_q, wr.data, wr.strb) & pwm_irq_pkg::EVENT_MASK;
				end
				pwm_irq_pkg::BRAKE_EN_OFS: begin
					if (unlocked) begin
						brk_en_d = pwm_irq_pkg::apply_strb(brk_en_q, wr.data, wr.strb) & pwm_irq_pkg::BRAKE_MASK;
					end
				end
				pwm_irq_pkg::EVENT_FLAG_OFS: begin
					ev_clr = wr_word & pwm_irq_pkg::EVENT_MASK;
				end
				pwm_irq_pkg::BRAKE_FLAG_OFS: begin
					brk_clr = wr_word & pwm_irq_pkg::BRAKE_MASK;
				end
				pwm_irq_pkg::SOFT_BRAKE_OFS: begin
					if (unlocked) begin
						lvl_trig_d = wr_word[pwm_irq_pkg::LEVEL_LSB +: pwm_irq_pkg::PAIRS];
						edge_trig_d = wr_word[pwm_irq_pkg::EDGE_LSB +: pwm_irq_pkg::PAIRS];
					end
				end
				default: begin
					ev_clr = pwm_irq_pkg::REG_RESET;
				end
			endcase
		end
		ev_flag_d = ((ev_flag_q & ~ev_clr) | ev_set) & pwm_irq_pkg::EVENT_MASK;
		brk_flag_d = ((brk_flag_q & ~brk_clr) | brk_set) & pwm_irq_pkg::BRAKE_MASK;
	end

	// ------------------------------------------------------------
	// interrupt gating
	// ------------------------------------------------------------
	assign ev_hot = ev_flag_q & ev_en_q;
	assign brk_hot = brk_flag_q & brk_en_q;

	generate
		for (genvar k = 0; k < pwm_irq_pkg::PAIRS; k++) begin : g_pair
			logic odd_hot;
			assign odd_hot = ev_hot[pwm_irq_pkg::CMPD_LSB + 2*k + 1] | ev_hot[pwm_irq_pkg::CMPU_LSB + 2*k + 1];
			assign chan_req[2*k] = ev_hot[pwm_irq_pkg::CMPD_LSB + 2*k] | ev_hot[pwm_irq_pkg::CMPU_LSB + 2*k] |
				ev_hot[pwm_irq_pkg::PERIOD_LSB + 2*k] | ev_hot[pwm_irq_pkg::ZERO_LSB + 2*k] |
				(comp_mode[k] & odd_hot);
			assign chan_req[2*k+1] = !comp_mode[k] & odd_hot;
		end
	endgenerate

	assign irq_d = (|chan_req) | (|brk_hot);

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ev_en_q <= pwm_irq_pkg::REG_RESET;
			brk_en_q <= pwm_irq_pkg::REG_RESET;
			ev_flag_q <= pwm_irq_pkg::REG_RESET;
			brk_flag_q <= pwm_irq_pkg::REG_RESET;
			lvl_trig_q <= '0;
			edge_trig_q <= '0;
			chan_irq_q <= '0;
			irq_q <= 1'b0;
		end else begin
			ev_en_q <= ev_en_d;
			brk_en_q <= brk_en_d;
			ev_flag_q <= ev_flag_d;
			brk_flag_q <= brk_flag_d;
			lvl_trig_q <= lvl_trig_d;
			edge_trig_q <= edge_trig_d;
			chan_irq_q <= chan_req;
			irq_q <= irq_d;
		end
	end

	assign soft_level_brake_trigger = lvl_trig_q;
	assign soft_edge_brake_trigger = edge_trig_q;
	assign chan_irq = chan_irq_q;
	assign pwm_irq = irq_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence locked_brake_write;
		wr.valid && wr.addr == pwm_irq_pkg::BRAKE_EN_OFS && register_write_lock;
	endsequence

	sequence soft_level_write;
		wr.valid && wr.addr == pwm_irq_pkg::SOFT_BRAKE_OFS && !register_write_lock &&
			wr.strb[1] && wr.data[pwm_irq_pkg::LEVEL_LSB];
	endsequence

	a_brake_lock_hold: assert property (locked_brake_write |=> $stable(brk_en_q))
		else $error("brake enable changed while locked");

	a_reset_enables_zero: assert property ($fell(srst) |-> ev_en_q == '0 && brk_en_q == '0)
		else $error("enable registers not zero after reset");

	a_reserved_zero: assert property ((ev_en_q & ~pwm_irq_pkg::EVENT_MASK) == '0 &&
		(brk_en_q & ~pwm_irq_pkg::BRAKE_MASK) == '0)
		else $error("reserved enable bit set");

	a_odd_zero_read: assert property (ev_en_q[pwm_irq_pkg::ZERO_LSB + 1] == 1'b0 &&
		ev_en_q[pwm_irq_pkg::ZERO_LSB + 3] == 1'b0)
		else $error("odd zero enable reads one");

	a_soft_level_flag: assert property (soft_level_write |=> soft_level_brake_trigger[0] &&
		brk_flag_q[pwm_irq_pkg::LEVEL_LSB])
		else $error("soft level trigger lost");

	a_cmpd_flag_set: assert property (events.cmp_down[0] |=> ev_flag_q[pwm_irq_pkg::CMPD_LSB])
		else $error("compare down flag not set");

	a_center_period: assert property (up_down_mode[0] && events.center_hit[0] |=>
		ev_flag_q[pwm_irq_pkg::PERIOD_LSB])
		else $error("centre point did not set period flag");

	a_comp_second_en: assert property (comp_mode[0] && ev_hot[pwm_irq_pkg::CMPD_LSB + 1] |=>
		chan_irq[0] && !chan_irq[1])
		else $error("odd compare down not steered to even channel");

	a_irq_follows: assert property (((ev_flag_q & ev_en_q) != '0) |=> pwm_irq)
		else $error("interrupt missing for enabled flag");

	a_irq_quiet: assert property (((ev_flag_q & ev_en_q) == '0 && (brk_flag_q & brk_en_q) == '0) |=>
		!pwm_irq)
		else $error("interrupt without enabled flag");

	sequence locked_trigger_write;
		wr.valid && wr.addr == pwm_irq_pkg::SOFT_BRAKE_OFS && register_write_lock;
	endsequence

	sequence cmpd_clear_write;
		wr.valid && wr.addr == pwm_irq_pkg::EVENT_FLAG_OFS && wr.strb[pwm_irq_pkg::CMPD_LSB / 8] &&
			wr.data[pwm_irq_pkg::CMPD_LSB] && !events.cmp_down[0];
	endsequence

	a_lock_no_trigger: assert property (locked_trigger_write |=> soft_level_brake_trigger == '0 &&
		soft_edge_brake_trigger == '0)
		else $error("soft trigger fired while locked");

	a_cmpd_flag_clear: assert property (cmpd_clear_write |=>
		!ev_flag_q[pwm_irq_pkg::CMPD_LSB])
		else $error("compare down flag not cleared");

	a_period_masked: assert property (up_down_mode[0] && !events.center_hit[0] &&
		!ev_flag_q[pwm_irq_pkg::PERIOD_LSB] |=> !ev_flag_q[pwm_irq_pkg::PERIOD_LSB])
		else $error("period end set flag in up-down mode");

	a_period_flag_set: assert property (!up_down_mode[1] && events.period_hit[1] |=>
		ev_flag_q[pwm_irq_pkg::PERIOD_LSB + 2])
		else $error("period flag not set");

	a_zero_gate: assert property (ev_hot[pwm_irq_pkg::ZERO_LSB] |=> chan_irq[0])
		else $error("enabled zero flag did not raise channel request");

	a_brake_irq: assert property (((brk_flag_q & brk_en_q) != '0) |=> pwm_irq)
		else $error("interrupt missing for enabled brake flag");

	a_odd_chan_quiet: assert property (comp_mode[0] |=> !chan_irq[1])
		else $error("odd channel request in complementary mode");

endmodule

// [sim/pwm_irq_enable_tb.sv]
`timescale 1ns/100ps
module pwm_irq_enable_tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	pwm_irq_pkg::pwm_events_t ev = '0;
	logic [2:0] comp_mode = 3'h0;
	logic [2:0] up_down_mode = 3'h0;
	logic lock = 1'b0;
	logic [2:0] slt;
	logic [2:0] set;
	logic [5:0] chan_irq;
	logic pwm_irq;
	int err_total = 0;
	int checks = 0;
	int lvl_cnt = 0;
	int edg_cnt = 0;
	logic [31:0] lf = 32'hafca19ef;
	logic [7:0] ra [4] = '{8'he0, 8'he4, 8'he8, 8'hec};

	pwm_irq_enable i_pwm_irq_enable (.ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.events(ev), .comp_mode(comp_mode), .up_down_mode(up_down_mode), .register_write_lock(lock),
		.soft_level_brake_trigger(slt), .soft_edge_brake_trigger(set), .chan_irq(chan_irq),
		.pwm_irq(pwm_irq));

	// ------------------------------------------------------------
	// clock, watchdog, trigger monitor
	// ------------------------------------------------------------
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		$display("unexpected at %0t: watchdog expired", $time);
		end_sim();
	end

	always @(posedge ref_clk) begin
		if (slt === 3'h1) lvl_cnt++;
		if (set === 3'h4) edg_cnt++;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic pwm_irq_pkg::pwm_events_t mk(input int f, input int b);
		pwm_irq_pkg::pwm_events_t e;
		e = '0;
		case (f)
			0: e.cmp_down[b] = 1'b1;
			1: e.cmp_up[b] = 1'b1;
			2: e.period_hit[b] = 1'b1;
			3: e.center_hit[b] = 1'b1;
			4: e.zero_hit[b] = 1'b1;
			5: e.edge_brake[b] = 1'b1;
			default: e.level_brake[b] = 1'b1;
		endcase
		return e;
	endfunction

	task automatic end_sim();
		if (err_total == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw;
		bit w;
		bit b;
		int n;
		aw = 0;
		w = 0;
		b = 0;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b && n < 100) begin
			@(posedge ref_clk);
			n++;
			if (aw && w && bvalid === 1'b1) begin
				r = bresp;
				b = 1;
			end
			if (!aw && awready === 1'b1) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		if (!b) begin
			err_total++;
			$display("unexpected at %0t: no write response", $time);
		end
		bready <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ar;
		bit b;
		int n;
		ar = 0;
		b = 0;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!b && n < 100) begin
			@(posedge ref_clk);
			n++;
			if (ar && rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				b = 1;
			end
			if (!ar && arready === 1'b1) begin
				ar = 1;
				arvalid <= 1'b0;
			end
		end
		if (!b) begin
			err_total++;
			$display("unexpected at %0t: no read response", $time);
		end
		rready <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, exp);
		chk(r, pwm_irq_pkg::RESP_OKAY);
	endtask

	task automatic ev_case(input pwm_irq_pkg::pwm_events_t e, input logic [7:0] fa, input logic [31:0] fb,
		input logic irq_exp, input logic [5:0] ch_exp, input bit ck);
		logic [1:0] r;
		ev <= e;
		@(posedge ref_clk);
		ev <= '0;
		repeat (3) @(posedge ref_clk);
		chk(pwm_irq, irq_exp);
		if (ck) chk(chan_irq, ch_exp);
		rchk(fa, fb);
		wr(fa, fb, r);
		repeat (3) @(posedge ref_clk);
		chk(pwm_irq, 1'b0);
		rchk(fa, 32'h0);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		foreach (ra[i]) rchk(ra[i], 32'h0);
		chk(pwm_irq, 1'b0);
		for (int i = 0; i < 12; i++) begin
			d = (i == 0) ? 32'hffff_ffff : lf;
			lf = lfsr(lf);
			comp_mode <= lf[2:0];
			wr(8'he0, d, r);
			rchk(8'he0, d & pwm_irq_pkg::EVENT_MASK);
		end
		comp_mode <= 3'h0;
		wr(8'he0, 32'hffff_ffff, r);
		ev_case(mk(0, 5), 8'he8, 32'h2000_0000, 1'b1, 6'h20, 1);
		ev_case(mk(1, 0), 8'he8, 32'h0001_0000, 1'b1, 6'h01, 1);
		ev_case(mk(2, 1), 8'he8, 32'h0000_0400, 1'b1, 6'h04, 1);
		ev_case(mk(4, 2), 8'he8, 32'h0000_0010, 1'b1, 6'h10, 1);
		up_down_mode <= 3'h1;
		ev_case(mk(2, 0), 8'he8, 32'h0, 1'b0, 6'h00, 1);
		ev_case(mk(3, 0), 8'he8, 32'h0000_0100, 1'b1, 6'h01, 1);
		up_down_mode <= 3'h0;
		wr(8'he0, 32'h0, r);
		ev_case(mk(0, 0), 8'he8, 32'h0100_0000, 1'b0, 6'h00, 1);
		comp_mode <= 3'h1;
		wr(8'he0, 32'h0200_0000, r);
		ev_case(mk(0, 1), 8'he8, 32'h0200_0000, 1'b1, 6'h01, 1);
		wr(8'he0, 32'h0002_0000, r);
		ev_case(mk(1, 1), 8'he8, 32'h0002_0000, 1'b1, 6'h01, 1);
		comp_mode <= 3'h0;
		wr(8'he4, 32'hffff_ffff, r);
		chk(r, pwm_irq_pkg::RESP_OKAY);
		rchk(8'he4, 32'h0000_0707);
		lock <= 1'b1;
		wr(8'he4, 32'h0, r);
		rchk(8'he4, 32'h0000_0707);
		lock <= 1'b0;
		ev_case(mk(5, 1), 8'hec, 32'h0000_0002, 1'b1, 6'h00, 0);
		ev_case(mk(6, 2), 8'hec, 32'h0000_0400, 1'b1, 6'h00, 0);
		wr(8'he4, 32'h0000_0100, r);
		rchk(8'he4, 32'h0000_0100);
		lock <= 1'b1;
		wr(8'hdc, 32'h0000_0104, r);
		chk(lvl_cnt, 0);
		rchk(8'hec, 32'h0);
		lock <= 1'b0;
		wr(8'hdc, 32'h0000_0104, r);
		repeat (3) @(posedge ref_clk);
		chk(lvl_cnt, 1);
		chk(edg_cnt, 1);
		chk(pwm_irq, 1'b1);
		rchk(8'hec, 32'h0000_0104);
		wr(8'hec, 32'h0000_0104, r);
		repeat (3) @(posedge ref_clk);
		chk(pwm_irq, 1'b0);
		wr(8'h40, 32'hffff_ffff, r);
		chk(r, pwm_irq_pkg::RESP_SLVERR);
		rd(8'h40, d, r);
		chk(r, pwm_irq_pkg::RESP_SLVERR);
		chk(d, 32'h0);
		wr(8'he0, 32'hffff_ffff, r);
		srst <= 1'b1;
		@(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		rchk(8'he0, 32'h0);
		rchk(8'he4, 32'h0);
		end_sim();
	end
endmodule
